// >>> node_id_edge.sv
// Rising and falling edge detector for one synchronous level.
// Assumes the input is already synchronous to the clock.
`default_nettype none
module node_id_edge (
   input wire logic i_ref_clk,
   input wire logic i_rstn,
   input wire logic i_level,
   output logic o_change
);
   logic prev_r;

   // Hold last value to spot any change
   always_ff @(posedge i_ref_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         prev_r <= 1'b0;
      end else begin
         prev_r <= i_level;
      end
   end

   assign o_change = prev_r ^ i_level;
endmodule : node_id_edge
`default_nettype wire

// >>> node_id_pkg.sv
// Package for the node identity register block.
// Assumes a single 100 MHz clock and a plain strobe register port.
`default_nettype none
package node_id_pkg;
   localparam logic [7:0] NODE_IDENTITY_OFS = 8'he8;
   localparam logic [7:0] INT_STATUS_OFS = 8'hc0;
   localparam logic [7:0] INT_MASK_OFS = 8'hc4;
   localparam int VALID_BIT = 31;
   localparam int ROOT_BIT = 30;
   localparam int CABLE_POWER_BIT = 27;
   localparam int SEG_LSB = 6;
   localparam int SEG_W = 10;
   localparam int NODE_W = 6;
   localparam logic [9:0] SEG_RESET = 10'h3ff;
   localparam logic [5:0] NODE_RESET = 6'h00;
   localparam logic [5:0] NODE_UNADDRESSED = 6'h3f;
   // Interrupt event bits
   localparam int EV_BUS_RESET = 0;
   localparam int EV_NODE_VALID = 1;
   localparam int EV_POWER_CHANGE = 2;
   localparam int EV_W = 3;
   localparam logic [2:0] EV_RESET = 3'h0;
endpackage : node_id_pkg
`default_nettype wire

// >>> node_id_reg.sv
// Node identity register: bus segment, PHY node number and status flags.
// Assumes PHY indications and bus reset are synchronous to i_ref_clk.
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
module node_id_reg (
   input wire logic i_ref_clk,
   input wire logic i_rstn,
   input wire logic [7:0] i_addr,
   input wire logic [31:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [31:0] o_rdata,
   input wire logic i_bus_reset,
   input wire logic i_phy_id_load,
   input wire logic [5:0] i_phy_node_number,
   input wire logic i_phy_root,
   input wire logic i_cable_power_ok,
   output logic [15:0] o_node_address,
   output logic o_node_id_valid,
   output logic o_unaddressed,
   output logic o_irq
);
   typedef struct packed {
      logic node_id_valid;
      logic root;
      logic cable_power_ok;
      logic [9:0] bus_segment_number;
      logic [5:0] physical_node_number;
      logic in_bus_reset;
      logic [2:0] int_mask;
      logic [31:0] rdata;
      logic irq;
      logic unaddressed;
   } state_t;

   state_t st_r;
   state_t st_nxt;
   logic [2:0] ev_set;
   logic [2:0] ev_clear;
   logic [2:0] ev_status;
   logic power_change;
   logic [31:0] ident_word;

   ////////////////////////////////////////////////////////////////////////////
   // Cable power edge, counts as an event either way
   node_id_edge u_power_edge (
      .i_ref_clk(i_ref_clk),
      .i_rstn(i_rstn),
      .i_level(i_cable_power_ok),
      .o_change(power_change)
   );

   // Write-one-to-clear only on the status offset
   always_comb begin
      ev_set = '0;
      ev_set[node_id_pkg::EV_BUS_RESET] = i_bus_reset;
      ev_set[node_id_pkg::EV_NODE_VALID] = i_phy_id_load & ~i_bus_reset;
      ev_set[node_id_pkg::EV_POWER_CHANGE] = power_change;
      ev_clear = '0;
      if (i_wr && i_addr == node_id_pkg::INT_STATUS_OFS) begin
         ev_clear = i_wdata[node_id_pkg::EV_W-1:0];
      end
   end

   node_id_sticky #(
      .W(node_id_pkg::EV_W)
   ) u_events (
      .i_ref_clk(i_ref_clk),
      .i_rstn(i_rstn),
      .i_set(ev_set),
      .i_clear(ev_clear),
      .o_status(ev_status)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Read image of the identity word; unused ranges stay zero
   always_comb begin
      ident_word = '0;
      ident_word[node_id_pkg::VALID_BIT] = st_r.node_id_valid;
      ident_word[node_id_pkg::ROOT_BIT] = st_r.root;
      ident_word[node_id_pkg::CABLE_POWER_BIT] = st_r.cable_power_ok;
      ident_word[15:0] = {st_r.bus_segment_number, st_r.physical_node_number};
   end

   // Next state of all flags, fields and the read port
   always_comb begin
      st_nxt = st_r;
      // Cable power follows the PHY report directly
      st_nxt.cable_power_ok = i_cable_power_ok;
      if (i_bus_reset) begin
         // Stale node number must not look valid once the bus resets
         st_nxt.node_id_valid = 1'b0;
         st_nxt.in_bus_reset = 1'b1;
         st_nxt.root = 1'b0;
      end else if (i_phy_id_load) begin
         st_nxt.physical_node_number = i_phy_node_number;
         st_nxt.node_id_valid = 1'b1;
         st_nxt.in_bus_reset = 1'b0;
         // Root only latched while reset processing is under way
         if (st_r.in_bus_reset) begin
            st_nxt.root = i_phy_root;
         end
      end
      // Only the segment field and the mask take software writes
      if (i_wr) begin
         case (i_addr)
            node_id_pkg::NODE_IDENTITY_OFS: begin
               st_nxt.bus_segment_number = i_wdata[15:node_id_pkg::SEG_LSB];
            end
            node_id_pkg::INT_MASK_OFS: begin
               st_nxt.int_mask = i_wdata[node_id_pkg::EV_W-1:0];
            end
            default: begin
            end
         endcase
      end
      // Read data valid the cycle after the strobe only
      st_nxt.rdata = '0;
      if (i_rd) begin
         case (i_addr)
            node_id_pkg::NODE_IDENTITY_OFS: st_nxt.rdata = ident_word;
            node_id_pkg::INT_STATUS_OFS: st_nxt.rdata = {29'h0, ev_status};
            node_id_pkg::INT_MASK_OFS: st_nxt.rdata = {29'h0, st_r.int_mask};
            default: st_nxt.rdata = '0;
         endcase
      end
      // Registered so the pin comes straight from a flip-flop
      st_nxt.unaddressed =
         (st_nxt.physical_node_number == node_id_pkg::NODE_UNADDRESSED);
      // Interrupt tracks status after this cycle's update
      st_nxt.irq = |(((ev_status & ~ev_clear) | ev_set) & st_nxt.int_mask);
   end

   ////////////////////////////////////////////////////////////////////////////
   // Single register stage for all state in st_r; event bits and power edge register in submodules
   always_ff @(posedge i_ref_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         st_r <= '0;
         st_r.bus_segment_number <= node_id_pkg::SEG_RESET;
         st_r.physical_node_number <= node_id_pkg::NODE_RESET;
         st_r.int_mask <= node_id_pkg::EV_RESET;
      end else begin
         st_r <= st_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs straight from flip-flops
   assign o_rdata = st_r.rdata;
   assign o_node_address = {st_r.bus_segment_number, st_r.physical_node_number};
   assign o_node_id_valid = st_r.node_id_valid;
   // Hint for transmit gating; software must still hold off itself
   assign o_unaddressed = st_r.unaddressed;
   assign o_irq = st_r.irq;
endmodule : node_id_reg
`default_nettype wire

// >>> node_id_reg_asserts.sv
// Checker: identity register port relations.
// Assumes a bind into node_id_reg, one clock.
`default_nettype none
module node_id_reg_asserts (
   input wire logic i_ref_clk,
   input wire logic i_rstn,
   input wire logic [7:0] i_addr,
   input wire logic [31:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic [31:0] o_rdata,
   input wire logic i_bus_reset,
   input wire logic i_phy_id_load,
   input wire logic [5:0] i_phy_node_number,
   input wire logic i_cable_power_ok,
   input wire logic [15:0] o_node_address,
   input wire logic o_node_id_valid
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking @(posedge i_ref_clk);
   endclocking
   default disable iff (!i_rstn);
   // Write then read of the identity word
   sequence s_rd; i_rd && i_addr == 8'he8; endsequence
   sequence s_wr_rd; i_wr && i_addr == 8'he8 ##2 s_rd; endsequence
   property p_addr; s_rd |=> o_rdata[15:0] == $past(o_node_address); endproperty
   a_addr: assert property (p_addr) else $error("addr");
   property p_clr; i_bus_reset |=> !o_node_id_valid; endproperty
   a_clr: assert property (p_clr) else $error("clr");
   property p_set; i_phy_id_load && !i_bus_reset |=> o_node_id_valid; endproperty
   a_set: assert property (p_set) else $error("set");
   property p_cps; s_rd ##0 $stable(i_cable_power_ok) |=> o_rdata[27] == $past(i_cable_power_ok);
   endproperty
   a_cps: assert property (p_cps) else $error("cps");
   property p_zero; s_rd |=> o_rdata[29:28] == 2'h0 && o_rdata[26:16] == 11'h000; endproperty
   a_zero: assert property (p_zero) else $error("zero");
   property p_seg; s_wr_rd |=> o_rdata[15:6] == $past(i_wdata[15:6], 3); endproperty
   a_seg: assert property (p_seg) else $error("seg");
   property p_nn; $rose(o_node_id_valid) |-> o_node_address[5:0] == $past(i_phy_node_number);
   endproperty
   a_nn: assert property (p_nn) else $error("nn");
   // Software write alone must not move the PHY node number
   property p_ro; i_wr && !i_phy_id_load && !i_bus_reset |=> $stable(o_node_address[5:0]);
   endproperty
   a_ro: assert property (p_ro) else $error("ro");
endmodule : node_id_reg_asserts
`default_nettype wire

// >>> node_id_reg_bench.sv
// Bench: register tasks, PHY model, bound checker.
// Assumes checker and PHY model compiled first.
`default_nettype none
module node_id_reg_bench;
   timeunit 1ns;
   timeprecision 100ps;
   logic i_ref_clk, i_rstn, i_wr, i_rd, br, ld, rt, pw, irq, vld, un;
   logic [7:0] addr;
   logic [31:0] wd, rdat;
   logic [5:0] nn;
   logic [15:0] na;
   int fails, total_checks;
   node_id_reg i_node_id_reg (.i_ref_clk, .i_rstn, .i_addr(addr), .i_wdata(wd), .i_wr, .i_rd,
      .o_rdata(rdat), .i_bus_reset(br), .i_phy_id_load(ld), .i_phy_node_number(nn),
      .i_phy_root(rt), .i_cable_power_ok(pw), .o_node_address(na), .o_node_id_valid(vld),
      .o_unaddressed(un), .o_irq(irq));
   phy_layer_model i_phy_layer_model (.i_ref_clk, .o_br(br), .o_ld(ld), .o_nn(nn),
      .o_root(rt), .o_pw(pw));
   initial begin
      i_ref_clk = 1'b0;
      forever #5 i_ref_clk = ~i_ref_clk;
   end
   task automatic chk(input logic [31:0] g, e);
      total_checks++;
      if (g !== e) begin
         fails++;
         $display("[FAIL] %0t got %h want %h", $time, g, e);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge i_ref_clk) {i_wr, addr, wd} <= {1'b1, a, d};
      @(posedge i_ref_clk) i_wr <= 1'b0;
   endtask : wr
   // Read data stands one cycle only, so sample right after
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge i_ref_clk) {i_rd, addr} <= {1'b1, a};
      @(posedge i_ref_clk) i_rd <= 1'b0;
      #1 chk(rdat, e);
   endtask : rd
   task automatic report_and_stop();
      $display("checks %0d fails %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : report_and_stop
   task automatic t_soft();
      rd(8'he8, 32'h0000ffc0);
      chk(na, 32'hffc0);
      wr(8'he8, 32'hffff1234);
      rd(8'he8, 32'h00001200);
      rd(8'h10, 32'h0);
      $display("software test done");
   endtask : t_soft
   task automatic t_phy();
      i_phy_layer_model.power(1'b1);
      i_phy_layer_model.bus_reset();
      i_phy_layer_model.self_id(6'h05, 1'b1);
      rd(8'he8, 32'hc8001205);
      i_phy_layer_model.bus_reset();
      rd(8'he8, 32'h08001205);
      i_phy_layer_model.self_id(6'h3f, 1'b0);
      rd(8'he8, 32'h8800123f);
      chk(un, 32'h1);
      $display("phy test done");
   endtask : t_phy
   task automatic t_irq();
      chk(irq, 32'h0);
      wr(8'hc4, 32'h7);
      rd(8'hc0, 32'h7);
      chk(irq, 32'h1);
      wr(8'hc0, 32'h7);
      rd(8'hc0, 32'h0);
      chk(irq, 32'h0);
      $display("irq test done");
   endtask : t_irq
   initial begin
      {i_rstn, i_wr, i_rd, addr, wd, fails, total_checks} = '0;
      repeat (3) @(posedge i_ref_clk);
      i_rstn <= 1'b1;
      t_soft();
      t_phy();
      t_irq();
      report_and_stop();
   end
endmodule : node_id_reg_bench
bind node_id_reg node_id_reg_asserts i_node_id_reg_asserts (.i_ref_clk, .i_rstn, .i_addr,
   .i_wdata, .i_wr, .i_rd, .o_rdata, .i_bus_reset, .i_phy_id_load, .i_phy_node_number,
   .i_cable_power_ok, .o_node_address, .o_node_id_valid);
`default_nettype wire

// >>> node_id_sticky.sv
// Sticky event bits, cleared by writing one; set wins over clear.
// Assumes event and clear vectors are single-cycle pulses.
`default_nettype none
module node_id_sticky #(
   parameter int W = 3
) (
   input wire logic i_ref_clk,
   input wire logic i_rstn,
   input wire logic [W-1:0] i_set,
   input wire logic [W-1:0] i_clear,
   output logic [W-1:0] o_status
);
   logic [W-1:0] stat_r;

   // Set beats clear so a coincident event survives
   always_ff @(posedge i_ref_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         stat_r <= '0;
      end else begin
         stat_r <= (stat_r & ~i_clear) | i_set;
      end
   end

   assign o_status = stat_r;
endmodule : node_id_sticky
`default_nettype wire

// >>> phy_layer_model.sv
// PHY layer model: bus reset, self-id report, cable power.
// Assumes one caller at a time.
`default_nettype none
module phy_layer_model (
   input wire logic i_ref_clk,
   output logic o_br,
   output logic o_ld,
   output logic [5:0] o_nn,
   output logic o_root,
   output logic o_pw
);
   timeunit 1ns;
   timeprecision 100ps;
   initial {o_br, o_ld, o_nn, o_root, o_pw} = 10'h0;
   task automatic bus_reset();
      @(posedge i_ref_clk) o_br <= 1'b1;
      @(posedge i_ref_clk) o_br <= 1'b0;
   endtask : bus_reset
   // Number only valid with strobe; inverted after
   task automatic self_id(input logic [5:0] n, input logic r);
      @(posedge i_ref_clk) {o_ld, o_nn, o_root} <= {1'b1, n, r};
      @(posedge i_ref_clk) {o_ld, o_nn, o_root} <= {1'b0, ~n, ~r};
   endtask : self_id
   task automatic power(input logic p);
      @(posedge i_ref_clk) o_pw <= p;
   endtask : power
endmodule : phy_layer_model
`default_nettype wire
